//--- pfg_pkg.sv
package pfg_pkg;
  // clock rate and derived tick counts
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_NS          = 10;
  localparam int unsigned HAMMER_GUARD_MS = 35;
  localparam int unsigned RAIL15_MS_X10   = 15;   // 1.5 ms in tenths
  localparam int unsigned RAIL5_US        = 1;
  localparam int unsigned MOTION_MS       = 8;
  localparam int unsigned LIFT_GUARD_MS   = 50;
  localparam int unsigned CLEAR_MS        = 150;
  localparam int unsigned RAISE_US        = 5000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned HAMMER_GUARD_CYC = HAMMER_GUARD_MS * CYC_PER_MS;
  localparam int unsigned RAIL15_CYC      = RAIL15_MS_X10 * CYC_PER_MS / 10;
  localparam int unsigned RAIL5_CYC       = RAIL5_US * 1000 / CLK_NS;
  localparam int unsigned MOTION_CYC      = MOTION_MS * CYC_PER_MS;
  localparam int unsigned LIFT_GUARD_CYC  = LIFT_GUARD_MS * CYC_PER_MS;
  localparam int unsigned CLEAR_CYC       = CLEAR_MS * CYC_PER_MS;
  localparam int unsigned RAISE_CYC       = RAISE_US * 1000 / CLK_NS;

  localparam int CNT_W = 25;
  localparam int POS_W = 8;
  localparam int DELTA_W = 8;
  localparam logic [2:0] SPEED_MID = 3'h4;
  localparam logic [DELTA_W-1:0] DELTA_ZERO = 8'h00;
  localparam logic [POS_W-1:0]   POS_ZERO   = 8'h00;

  // rail monitor inputs, active high = failing
  typedef struct packed {
    logic p15;
    logic n15;
    logic p5;
  } pfg_rail_t;

  // ribbon lift drive outputs
  typedef struct packed {
    logic raise;
    logic hold;
  } pfg_lift_t;

  typedef enum logic [1:0] {
    PFG_INIT_CLEAR,
    PFG_INIT_SEEK,
    PFG_INIT_RIGHT,
    PFG_INIT_DONE
  } pfg_init_t;
endpackage

//--- pfg_timer.sv
// loadable down-counter; busy while nonzero, done pulses at expiry
module pfg_timer
  import pfg_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] count,
  output logic                  busy,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // load wins over counting, which gives retriggering
  assign cnt_d = load ? count :
                 (cnt_q != '0) ? cnt_q - CNT_W'(1) : cnt_q;
  assign busy  = (cnt_q != '0);

  // count register and one-cycle expiry flag
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      done  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done  <= !load && (cnt_q == CNT_W'(1));
    end
  end
endmodule

//--- pfg_top.sv
// What this block does
// - hammer drive conducts while the active-low fire input is low.
// - fire leading edge starts an independent 35 ms guard timer.
// - fire still low at guard expiry cuts drive until pulse ends.
// - lift command asserts the high-current raise output at lift start.
// - hold output stays on for the rest of the print cycle.
// - a protection timer bounds how long lift coils stay energised.
// - 15 V rail fault lasting over 1.5 ms sets the fault latch.
// - fault latch disables carriage servo and drives host fault output.
// - 5 V rail fault lasting over 1 us sets the fault latch.
// - a move command starts the motion timer before any carriage clock.
// - each carriage clock within 8 ms retriggers the motion timer.
// - no carriage clock within the window expires timer, sets fault.
// - while faulted all printer actions stay blocked until restore.
// - restore cannot clear the latch while any rail still fails.
// - power-on reset yields an active-low clear pulse of 150 ms.
// - clear zeroes the carriage delta counter and the absolute wheel counter.
// - homing load via strobes two and three gives mid speed leftward.
// - left-stop signal goes onto the bus while select four active.
// - after left stop the carriage stops, then moves right a detent.
// - index coinciding with phase one zeroes the absolute counter.
// - zeroed absolute counter tracks printwheel clock pulses.
// - absolute counter steps up or down per phase one by direction.
// - carriage clock phase chosen from direction, counts the counter.
module pfg_top
  import pfg_pkg::*;
// tick counts of every guard and filter interval
#(
  parameter int unsigned HAMMER_GUARD_TICKS = HAMMER_GUARD_CYC,
  parameter int unsigned LIFT_GUARD_TICKS   = LIFT_GUARD_CYC,
  parameter int unsigned RAISE_TICKS        = RAISE_CYC,
  parameter int unsigned RAIL15_TICKS       = RAIL15_CYC,
  parameter int unsigned RAIL5_TICKS        = RAIL5_CYC,
  parameter int unsigned MOTION_TICKS       = MOTION_CYC,
  parameter int unsigned CLEAR_TICKS        = CLEAR_CYC
)
(
  input  wire logic               ref_clk,
  input  wire logic               rstn,
  input  wire logic               hammer_fire_n,
  input  wire logic               lift_cmd,
  input  wire logic               print_cycle,
  input  wire pfg_rail_t          rail_fail,
  input  wire logic               move_cmd,
  input  wire logic               clk_x,
  input  wire logic               clk_y,
  input  wire logic               carriage_dir_left,
  input  wire logic               restore_cmd,
  input  wire logic               out_strobe_two,
  input  wire logic               out_strobe_three,
  input  wire logic [DELTA_W-1:0] delta_load,
  input  wire logic               in_select_four,
  input  wire logic               carriage_left_stop,
  input  wire logic               wheel_index,
  input  wire logic               wheel_phase_one,
  input  wire logic               wheel_dir_up,
  output logic                    hammer_drive,
  output pfg_lift_t               lift_drive,
  output logic                    servo_disable,
  output logic                    fault_out,
  output logic                    init_clear_pulse_n,
  output logic [DELTA_W-1:0]      carriage_delta,
  output logic [2:0]              carriage_speed,
  output logic                    carriage_left,
  output logic                    carriage_speed_mid,
  output logic                    io_left_limit,
  output logic [POS_W-1:0]        wheel_abs_pos,
  output logic                    wheel_pos_valid,
  output logic                    init_done
);
  // two-stage synchronisers for 14 pin inputs; strobes, select four, restore and delta load bypass them
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  // reset to each pin's idle level; fire idles high, so no false edge
  localparam logic [NSYNC-1:0] SYNC_IDLE = {1'b1, {(NSYNC-1){1'b0}}};
  assign pin_raw = {hammer_fire_n, lift_cmd, print_cycle, rail_fail.p15,
                    rail_fail.n15, rail_fail.p5, clk_x, clk_y,
                    carriage_left_stop, wheel_index, wheel_phase_one,
                    wheel_dir_up, carriage_dir_left, move_cmd};
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          sync1_q[i] <= SYNC_IDLE[i];
          sync2_q[i] <= SYNC_IDLE[i];
        end else begin
          sync1_q[i] <= pin_raw[i];
          sync2_q[i] <= sync1_q[i];
        end
      end
    end
  endgenerate

  logic fire_s, lift_s, cyc_s, f15p_s, f15n_s, f5_s, cx_s, cy_s;
  logic lstop_s, idx_s, ph1_s, wup_s, cdir_s, move_s;
  assign {fire_s, lift_s, cyc_s, f15p_s, f15n_s, f5_s, cx_s, cy_s,
          lstop_s, idx_s, ph1_s, wup_s, cdir_s, move_s} = sync2_q;
  logic fire_on;
  assign fire_on = !fire_s; // fire is active low

  // edge history
  logic fire_on_q, lift_q, ph1_q, cclk_q;
  logic fault_q, rail_any;

  // hammer: edge loads guard, drive gated after guard expiry
  logic hammer_edge, hammer_guard_busy, hammer_guard_done, hammer_cut_q;
  assign hammer_edge = fire_on && !fire_on_q;
  pfg_timer u_hammer_guard (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (hammer_edge),
    .count   (CNT_W'(HAMMER_GUARD_TICKS)),
    .busy    (hammer_guard_busy),
    .done    (hammer_guard_done)
  );

  // ribbon lift: raise at start, hold for cycle, guard bounds both
  logic lift_edge, lift_active_q, lift_guard_busy, lift_guard_done;
  logic raise_busy;
  assign lift_edge = lift_s && !lift_q && cyc_s && !fault_q;
  pfg_timer u_lift_guard (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (lift_edge),
    .count   (CNT_W'(LIFT_GUARD_TICKS)),
    .busy    (lift_guard_busy),
    .done    (lift_guard_done)
  );
  pfg_timer u_raise (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (lift_edge),
    .count   (CNT_W'(RAISE_TICKS)),
    .busy    (raise_busy),
    .done    ()
  );

  // rail persistence filters
  logic r15_busy, r15_done, r5_busy, r5_done, r15_any;
  assign r15_any  = f15p_s || f15n_s;
  assign rail_any = r15_any || f5_s;
  pfg_timer u_rail15 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (!r15_any),
    .count   (CNT_W'(RAIL15_TICKS)),
    .busy    (r15_busy),
    .done    (r15_done)
  );
  pfg_timer u_rail5 (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (!f5_s),
    .count   (CNT_W'(RAIL5_TICKS)),
    .busy    (r5_busy),
    .done    (r5_done)
  );

  // carriage clock with direction-dependent phase
  logic cclk, cclk_pulse, arm_q, mot_busy, mot_done;
  assign cclk       = cdir_s ? (cx_s && !cy_s) : (cy_s && !cx_s);
  assign cclk_pulse = cclk && !cclk_q;
  pfg_timer u_motion (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (cclk_pulse || (move_s && !arm_q && !mot_busy)),
    .count   (CNT_W'(MOTION_TICKS)),
    .busy    (mot_busy),
    .done    (mot_done)
  );

  // fault latch set and clear conditions
  logic fault_set, fault_clr;
  assign fault_set = r15_done || r5_done || (mot_done && arm_q);
  assign fault_clr = restore_cmd && !rail_any;

  // power-on clear pulse
  logic clr_busy, clr_start_q;
  pfg_timer u_clear (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .load    (clr_start_q),
    .count   (CNT_W'(CLEAR_TICKS)),
    .busy    (clr_busy),
    .done    ()
  );
  logic clearing;
  assign clearing = clr_start_q || clr_busy;

  // init sequence and wheel counters
  pfg_init_t  init_q, init_d;
  logic       strobe_load, ph1_edge, wheel_zero;
  assign strobe_load = out_strobe_two && out_strobe_three && !fault_q;
  assign ph1_edge    = ph1_s && !ph1_q;
  assign wheel_zero  = ph1_edge && idx_s;

  always_comb begin
    init_d = init_q;
    case (init_q)
      PFG_INIT_CLEAR: if (!clearing) init_d = PFG_INIT_SEEK;
      PFG_INIT_SEEK:  if (lstop_s) init_d = PFG_INIT_RIGHT;
      PFG_INIT_RIGHT: if (strobe_load)
                        init_d = PFG_INIT_DONE;
      PFG_INIT_DONE:  init_d = PFG_INIT_DONE;
      default:        init_d = PFG_INIT_CLEAR;
    endcase
  end

  // direction of the last delta load; only a load in seek runs leftward
  logic carriage_left_q;

  // edge histories, fault latch and lift state
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fire_on_q     <= 1'b0;
      lift_q        <= 1'b0;
      ph1_q         <= 1'b0;
      cclk_q        <= 1'b0;
      clr_start_q   <= 1'b1;
      fault_q       <= 1'b0;
      arm_q         <= 1'b0;
      hammer_cut_q  <= 1'b0;
      lift_active_q <= 1'b0;
    end else begin
      fire_on_q   <= fire_on;
      lift_q      <= lift_s;
      ph1_q       <= ph1_s;
      cclk_q      <= cclk;
      clr_start_q <= 1'b0;
      if (fault_set)
        fault_q <= 1'b1; // set wins over restore
      else if (fault_clr)
        fault_q <= 1'b0;
      // motion watch armed by a move, dropped when the move command ends
      if (move_s && !fault_q)
        arm_q <= 1'b1;
      else if (!move_s || mot_done)
        arm_q <= 1'b0;
      if (!fire_on)
        hammer_cut_q <= 1'b0;
      else if (hammer_guard_done)
        hammer_cut_q <= 1'b1;
      if (lift_edge)
        lift_active_q <= 1'b1;
      else if (!cyc_s || lift_guard_done || fault_q)
        lift_active_q <= 1'b0;
    end
  end

  // carriage delta counter, init state and wheel position
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      init_q          <= PFG_INIT_CLEAR;
      carriage_delta  <= DELTA_ZERO;
      carriage_speed  <= '0;
      carriage_left_q <= 1'b0;
      wheel_abs_pos   <= POS_ZERO;
      wheel_pos_valid <= 1'b0;
    end else begin
      init_q <= init_d;
      if (clearing) begin
        carriage_delta  <= DELTA_ZERO;
        carriage_speed  <= '0;
        wheel_abs_pos   <= POS_ZERO;
        wheel_pos_valid <= 1'b0;
      end else begin
        if (strobe_load) begin
          carriage_delta  <= delta_load;
          carriage_speed  <= SPEED_MID;
          carriage_left_q <= (init_q == PFG_INIT_SEEK);
        end else if (init_q == PFG_INIT_SEEK && lstop_s) begin
          carriage_delta <= DELTA_ZERO;
          carriage_speed <= '0;
        end else if (cclk_pulse && carriage_delta != DELTA_ZERO) begin
          carriage_delta <= carriage_delta - DELTA_W'(1);
          if (carriage_delta == DELTA_W'(1))
            carriage_speed <= '0;
        end
        if (wheel_zero) begin
          wheel_abs_pos   <= POS_ZERO;
          wheel_pos_valid <= 1'b1;
        end else if (ph1_edge && wheel_pos_valid) begin
          wheel_abs_pos <= wup_s ? wheel_abs_pos + POS_W'(1)
                                 : wheel_abs_pos - POS_W'(1);
        end
      end
    end
  end

  // drive outputs; hammer blocked while faulted or clearing, lift dropped once faulted
  assign hammer_drive = fire_on && !hammer_cut_q && !fault_q
                        && !clearing;
  assign lift_drive.raise = lift_active_q && raise_busy;
  assign lift_drive.hold  = lift_active_q && !raise_busy;
  assign servo_disable = fault_q;
  assign fault_out     = fault_q;
  assign init_clear_pulse_n = !clearing;
  assign carriage_left      = carriage_left_q;
  assign carriage_speed_mid = (carriage_speed == SPEED_MID);
  assign io_left_limit = in_select_four && lstop_s;
  assign init_done     = (init_q == PFG_INIT_DONE);
endmodule

//--- pfg_top_asserts.sv
module pfg_top_asserts
  import pfg_pkg::*;
#(
  parameter int unsigned HG_TICKS  = HAMMER_GUARD_CYC,
  parameter int unsigned LG_TICKS  = LIFT_GUARD_CYC,
  parameter int unsigned R5_TICKS  = RAIL5_CYC,
  parameter int unsigned CLR_TICKS = CLEAR_CYC
)
(
  input wire logic               ref_clk,
  input wire logic               rstn,
  input wire logic               hammer_fire_n,
  input wire pfg_rail_t          rail_fail,
  input wire logic               out_strobe_two,
  input wire logic               out_strobe_three,
  input wire logic [DELTA_W-1:0] delta_load,
  input wire logic               in_select_four,
  input wire logic               hammer_drive,
  input wire pfg_lift_t          lift_drive,
  input wire logic               servo_disable,
  input wire logic               fault_out,
  input wire logic               init_clear_pulse_n,
  input wire logic [DELTA_W-1:0] carriage_delta,
  input wire logic [2:0]         carriage_speed,
  input wire logic               io_left_limit
);
  int hd_q, lf_q, cl_q, p5_q;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // run lengths of hammer drive, lift drive and 5 v fault, and total clear cycles
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) hd_q <= 0;
    else hd_q <= hammer_drive ? hd_q + 1 : 0;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) lf_q <= 0;
    else lf_q <= (lift_drive != '0) ? lf_q + 1 : 0;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) cl_q <= 0;
    else cl_q <= !init_clear_pulse_n ? cl_q + 1 : cl_q;
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn) p5_q <= 0;
    else p5_q <= (rail_fail.p5 && init_clear_pulse_n) ? p5_q + 1 : 0;

  // drive follows the synced fire level and the guard
  hammer_level_a: assert property (
    hammer_drive |-> !$past(hammer_fire_n, 2) || !$past(hammer_fire_n, 3))
    else $error("hammer drive without fire");
  hammer_guard_a: assert property (
    hd_q <= HG_TICKS + 4)
    else $error("hammer drive beyond guard");
  lift_guard_a: assert property (
    lf_q <= LG_TICKS + 4)
    else $error("lift drive beyond guard");
  fault_servo_a: assert property (
    servo_disable == fault_out)
    else $error("servo disable differs from fault");
  rail5_set_a: assert property (
    p5_q == R5_TICKS + 4 |-> fault_out)
    else $error("5 v fault did not latch");
  action_block_a: assert property (
    fault_out && $past(fault_out) |-> !hammer_drive && lift_drive == '0)
    else $error("action while faulted");
  rail_hold_a: assert property (
    fault_out && rail_fail != '0 |=> fault_out)
    else $error("fault cleared while rail fails");
  clear_width_a: assert property (
    $rose(init_clear_pulse_n) |-> cl_q >= CLR_TICKS && cl_q <= CLR_TICKS + 2)
    else $error("clear pulse width off");
  clear_zero_a: assert property (
    !init_clear_pulse_n |-> carriage_delta == DELTA_ZERO)
    else $error("delta nonzero during clear");
  strobe_load_a: assert property (
    out_strobe_two && out_strobe_three && init_clear_pulse_n && !fault_out
    |=> carriage_delta == $past(delta_load) && carriage_speed == SPEED_MID)
    else $error("strobe load wrong");
  limit_gate_a: assert property (
    io_left_limit |-> in_select_four)
    else $error("left limit without select");
endmodule

bind pfg_top pfg_top_asserts #(
  .HG_TICKS  (HAMMER_GUARD_TICKS),
  .LG_TICKS  (LIFT_GUARD_TICKS),
  .R5_TICKS  (RAIL5_TICKS),
  .CLR_TICKS (CLEAR_TICKS)
) u_chk (
  .ref_clk, .rstn, .hammer_fire_n, .rail_fail, .out_strobe_two,
  .out_strobe_three, .delta_load, .in_select_four, .hammer_drive,
  .lift_drive, .servo_disable, .fault_out, .init_clear_pulse_n,
  .carriage_delta, .carriage_speed, .io_left_limit
);

//--- pfg_mech.sv
module pfg_mech
(
  input  wire logic ref_clk,
  input  wire logic move_cmd,
  input  wire logic servo_disable,
  input  wire logic stall,
  input  wire logic carriage_left,
  input  wire logic spin,
  input  wire logic wheel_dir_up,
  output logic      clk_x,
  output logic      clk_y,
  output logic      carriage_left_stop,
  output logic      wheel_index,
  output logic      wheel_phase_one
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_q = 3'h0;
  logic [1:0] ph_q  = 2'h0;
  logic [7:0] pos_q = 8'h06;
  logic [3:0] sp_q  = 4'hD;
  logic       pul_q = 1'b0;
  wire        step  = div_q == 3'h7;
  wire        move  = step && move_cmd && !servo_disable && !stall &&
                      !(carriage_left && carriage_left_stop);

  // photocell phases, left stop sensor and wheel index
  assign clk_x = ph_q[1];
  assign clk_y = ph_q[1] ^ ph_q[0];
  assign carriage_left_stop = pos_q == 8'h00;
  assign wheel_index = sp_q == 4'h0;
  assign wheel_phase_one = pul_q;

  // carriage steps one detent per 8 cycles, wheel likewise
  always @(posedge ref_clk) begin
    div_q <= div_q + 3'h1;
    if (move) begin
      ph_q  <= carriage_left ? ph_q - 2'h1 : ph_q + 2'h1;
      pos_q <= carriage_left ? pos_q - 8'h01 : pos_q + 8'h01;
    end
    pul_q <= step && spin;
    if (step && spin)
      sp_q <= wheel_dir_up ? sp_q + 4'h1 : sp_q - 4'h1;
  end
endmodule

//--- testbench.sv
module testbench
  import pfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rstn, hammer_fire_n, lift_cmd, print_cycle, move_cmd, restore_cmd;
  logic out_strobe_two, out_strobe_three, in_select_four, wheel_dir_up;
  logic stall, spin, clk_x, clk_y, carriage_left_stop, wheel_index;
  logic wheel_phase_one, hammer_drive, servo_disable, fault_out;
  logic init_clear_pulse_n, carriage_left, carriage_speed_mid;
  logic io_left_limit, wheel_pos_valid, init_done;
  logic [DELTA_W-1:0] delta_load, carriage_delta;
  logic [2:0]         carriage_speed;
  logic [POS_W-1:0]   wheel_abs_pos;
  pfg_rail_t          rail_fail;
  pfg_lift_t          lift_drive;
  int                 err_count = 0, checks = 0, cyc, k;
  // shortened tick counts keep the run to a few thousand cycles
  localparam int unsigned T_CLR = 200;
  localparam int unsigned T_HG  = 400;
  localparam int unsigned T_LG  = 600;
  localparam int unsigned T_RS  = 100;
  localparam int unsigned T_R15 = 150;
  localparam int unsigned T_MOT = 300;

  pfg_top #(
    .HAMMER_GUARD_TICKS (T_HG),
    .LIFT_GUARD_TICKS   (T_LG),
    .RAISE_TICKS        (T_RS),
    .RAIL15_TICKS       (T_R15),
    .RAIL5_TICKS        (RAIL5_CYC),
    .MOTION_TICKS       (T_MOT),
    .CLEAR_TICKS        (T_CLR)
  ) u_pfg_top (
    .ref_clk, .rstn, .hammer_fire_n, .lift_cmd, .print_cycle, .rail_fail,
    .move_cmd, .clk_x, .clk_y, .carriage_dir_left(carriage_left),
    .restore_cmd, .out_strobe_two, .out_strobe_three, .delta_load,
    .in_select_four, .carriage_left_stop, .wheel_index, .wheel_phase_one,
    .wheel_dir_up, .hammer_drive, .lift_drive, .servo_disable, .fault_out,
    .init_clear_pulse_n, .carriage_delta, .carriage_speed, .carriage_left,
    .carriage_speed_mid, .io_left_limit, .wheel_abs_pos, .wheel_pos_valid,
    .init_done
  );
  pfg_mech u_pfg_mech (
    .ref_clk, .move_cmd, .servo_disable, .stall, .carriage_left, .spin,
    .wheel_dir_up, .clk_x, .clk_y, .carriage_left_stop, .wheel_index,
    .wheel_phase_one
  );

  always #5 ref_clk = ~ref_clk;

  // inputs move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
    cyc += n;
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk8(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  function automatic bit pick(input int s);
    return (s == 0) ? init_clear_pulse_n === 1'b1 :
           (s == 1) ? fault_out === 1'b1 : carriage_left_stop === 1'b1;
  endfunction

  // bounded wait; running out ends the run
  task automatic wait_hi(input int n, input int s);
    int i;
    for (i = 0; i < n && !pick(s); i++) tick(1);
    if (i == n) begin
      err_count++;
      summarize();
    end
  endtask

  task automatic restore;
    restore_cmd = 1'b1;
    tick(1);
    restore_cmd = 1'b0;
    tick(3);
  endtask

  task automatic load(input logic [7:0] v);
    delta_load = v;
    {out_strobe_two, out_strobe_three} = 2'h3;
    tick(1);
    {out_strobe_two, out_strobe_three} = 2'h0;
    tick(1);
  endtask

  // main sequence
  initial begin
    {rstn, lift_cmd, print_cycle, move_cmd, restore_cmd} = '0;
    {out_strobe_two, out_strobe_three, in_select_four} = '0;
    {wheel_dir_up, stall, spin} = '0;
    hammer_fire_n = 1'b1;
    rail_fail = '0;
    delta_load = '0;
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    cyc = 0;
    chk1("clear_n", 1'b0, init_clear_pulse_n);
    load(8'h5A);
    chk8("delta", DELTA_ZERO, carriage_delta);
    wait_hi(T_CLR + 10, 0);
    chk1("clear_len", 1'b1, cyc >= T_CLR && cyc <= T_CLR + 3);
    chk1("pos_valid", 1'b0, wheel_pos_valid);
    // wheel passes its index going up, then steps back
    wheel_dir_up = 1'b1;
    spin = 1'b1;
    tick(64);
    spin = 1'b0;
    tick(6);
    chk8("abs_pos", {4'h0, u_pfg_mech.sp_q}, wheel_abs_pos);
    chk1("pos_valid", 1'b1, wheel_pos_valid);
    wheel_dir_up = 1'b0;
    spin = 1'b1;
    tick(16);
    spin = 1'b0;
    tick(6);
    chk8("abs_pos", {4'h0, u_pfg_mech.sp_q}, wheel_abs_pos);
    // homing toward the left stop
    load(8'h30);
    chk8("delta", 8'h30, carriage_delta);
    chk8("speed", {5'h00, SPEED_MID}, {5'h00, carriage_speed});
    chk1("left", 1'b1, carriage_left);
    chk1("speed_mid", 1'b1, carriage_speed_mid);
    move_cmd = 1'b1;
    wait_hi(400, 2);
    move_cmd = 1'b0;
    in_select_four = 1'b1;
    tick(4);
    chk1("left_limit", 1'b1, io_left_limit);
    in_select_four = 1'b0;
    tick(1);
    chk1("left_limit", 1'b0, io_left_limit);
    load(8'h10);
    chk1("left", 1'b0, carriage_left);
    chk1("init_done", 1'b1, init_done);
    // long move keeps the motion timer alive, a jam trips it
    move_cmd = 1'b1;
    tick(3 * T_MOT);
    chk1("fault", 1'b0, fault_out);
    stall = 1'b1;
    tick(T_MOT - 100);
    chk1("fault", 1'b0, fault_out);
    wait_hi(300, 1);
    chk1("servo_off", 1'b1, servo_disable);
    hammer_fire_n = 1'b0;
    tick(6);
    chk1("hammer", 1'b0, hammer_drive);
    hammer_fire_n = 1'b1;
    {stall, move_cmd} = 2'h0;
    restore();
    chk1("fault", 1'b0, fault_out);
    // short 5 v glitch, then a held one, restore refused meanwhile
    rail_fail.p5 = 1'b1;
    tick(20);
    rail_fail.p5 = 1'b0;
    tick(10);
    chk1("fault", 1'b0, fault_out);
    rail_fail.p5 = 1'b1;
    wait_hi(RAIL5_CYC + 20, 1);
    restore();
    chk1("fault", 1'b1, fault_out);
    rail_fail.p5 = 1'b0;
    tick(3);
    restore();
    chk1("fault", 1'b0, fault_out);
    // each 15 v rail in turn
    for (k = 0; k < 2; k++) begin
      rail_fail = pfg_rail_t'(k == 0 ? 3'h4 : 3'h2);
      tick(T_R15 - 100);
      chk1("fault", 1'b0, fault_out);
      wait_hi(300, 1);
      chk1("servo_off", 1'b1, servo_disable);
      rail_fail = '0;
      tick(3);
      restore();
    end
    // stuck fire is cut by the guard, then a normal pulse
    hammer_fire_n = 1'b0;
    tick(T_HG - 10);
    chk1("hammer", 1'b1, hammer_drive);
    tick(20);
    chk1("hammer", 1'b0, hammer_drive);
    hammer_fire_n = 1'b1;
    tick(5);
    hammer_fire_n = 1'b0;
    tick(5);
    chk1("hammer", 1'b1, hammer_drive);
    tick(T_HG / 2);
    chk1("hammer", 1'b1, hammer_drive);
    hammer_fire_n = 1'b1;
    tick(5);
    chk1("hammer", 1'b0, hammer_drive);
    // ribbon lift within a print cycle
    print_cycle = 1'b1;
    tick(3);
    lift_cmd = 1'b1;
    tick(4);
    chk1("raise", 1'b1, lift_drive.raise);
    tick(T_RS);
    chk1("raise", 1'b0, lift_drive.raise);
    chk1("hold", 1'b1, lift_drive.hold);
    {print_cycle, lift_cmd} = 2'h0;
    tick(5);
    chk1("hold", 1'b0, lift_drive.hold);
    summarize();
  end
endmodule
